//--- verilog/csac_pkg.sv
// Constants, register map and carrier types for the slip assist control.
// What this block and its software do
// RULE_01: Imminent slip switches on one extra cell.
// RULE_02: Extra cells drive steady, unpulsed constant current.
// RULE_03: Each further slip adds one cell, seven maximum.
// RULE_04: After overshoot, cells switch off one by one.
// RULE_05: Assistance works only while enable bit set.
// RULE_06: Software keeps detector input duty between 45-55%.
// RULE_07: Software should halve divider and enable halver.
// RULE_08: Software enables assistance only with positive polarity.
// RULE_09: Software sets charge pump current to minimum.
// RULE_10: Halver enabled inserts toggle before phase detector.
// RULE_11: Disabled keeps all cells off, clearing active ones.
package csac_pkg;

  // ==========================================================
  // Sizes and timing
  // ==========================================================
  localparam int unsigned MAX_CELLS      = 7;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned STEP_TIME_NS   = 100;
  localparam int unsigned STEP_CYCLES    =
    (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register map (byte addresses, one word each)
  // ==========================================================
  localparam logic [7:0] REF_DIVIDER_OFS = 8'h00;
  localparam logic [7:0] FUNC_SETUP_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS      = 8'h08;

  localparam int unsigned SLIP_ASSIST_BIT_POS   = 28;
  localparam int unsigned REF_HALVER_BIT_POS    = 21;
  localparam int unsigned DETECTOR_POL_BIT_POS  = 6;
  localparam int unsigned STATUS_CELLS_POS      = 0;
  localparam int unsigned STATUS_SOURCE_POS     = 8;
  localparam int unsigned STATUS_STATE_POS      = 12;

  localparam logic [31:0] REF_DIVIDER_RST = 32'h0000_0000;
  localparam logic [31:0] FUNC_SETUP_RST  = 32'h0000_0000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CSAC_IDLE,
    CSAC_RAMP_UP,
    CSAC_RAMP_DOWN
  } csac_state_e;

  // Events from the phase detector; raise means tuning voltage must rise.
  typedef struct packed {
    logic slip_imminent;
    logic overshoot;
    logic raise;
  } csac_detect_s;

  // Extra cell controls: a thermometer of enables plus the direction.
  typedef struct packed {
    logic [MAX_CELLS-1:0] cells;
    logic                 source;
  } csac_cells_s;

endpackage

//--- verilog/csac_top.sv
// Slip assist control: APB registers, cell ramp and reference halver.
`timescale 1ns/10ps
module csac_top #(
  parameter int unsigned STEP_CYCLES = csac_pkg::STEP_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire csac_pkg::csac_detect_s detect,
  input  wire logic                 ref_count_pulse,
  output logic                      pfd_ref,
  output csac_pkg::csac_cells_s     cell_ctrl,
  output logic                      slip_assist_enable
);
  import csac_pkg::*;

  // ==========================================================
  // Register bus
  // ==========================================================
  logic [31:0]             ref_div_ff;
  logic [31:0]             func_ff;
  logic [31:0]             prdata_ff;
  logic                    pslverr_ff;
  logic [MAX_CELLS-1:0]    cells_ff;
  logic                    source_ff;
  logic                    pfd_ref_ff;
  csac_state_e             state_ff;
  logic [15:0]             step_cnt_ff;
  logic                    mapped;
  logic                    wr_go;
  logic                    halver_en;
  logic                    step_tick;

  assign mapped = (paddr == REF_DIVIDER_OFS) || (paddr == FUNC_SETUP_OFS) ||
                  (paddr == STATUS_OFS);
  assign wr_go  = psel && penable && pwrite;
  // Zero wait states; read data is captured in the setup cycle.
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_div_ff <= REF_DIVIDER_RST;
      func_ff    <= FUNC_SETUP_RST;
    end else if (wr_go && paddr == REF_DIVIDER_OFS) begin
      ref_div_ff <= pwdata;
    end else if (wr_go && paddr == FUNC_SETUP_OFS) begin
      func_ff <= pwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_ff <= !mapped;
      case (paddr)
        REF_DIVIDER_OFS: prdata_ff <= ref_div_ff;
        FUNC_SETUP_OFS:  prdata_ff <= func_ff;
        STATUS_OFS: begin
          prdata_ff <= 32'h0000_0000;
          prdata_ff[STATUS_CELLS_POS +: MAX_CELLS] <= cells_ff;
          prdata_ff[STATUS_SOURCE_POS] <= source_ff;
          prdata_ff[STATUS_STATE_POS +: 2] <= state_ff;
        end
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign slip_assist_enable = ref_div_ff[SLIP_ASSIST_BIT_POS];
  assign halver_en          = ref_div_ff[REF_HALVER_BIT_POS];

  // ==========================================================
  // Reference halver
  // ==========================================================
  // Without the halver the counter pulse is passed through one flop,
  // so both paths share the same latency into the detector.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pfd_ref_ff <= 1'b0;
    end else if (halver_en) begin
      pfd_ref_ff <= pfd_ref_ff ^ ref_count_pulse; // RULE_10
    end else begin
      pfd_ref_ff <= ref_count_pulse;
    end
  end
  assign pfd_ref = pfd_ref_ff;

  a_halver_toggle: assert property ( // RULE_10
    @(posedge clk) disable iff (sys_rst)
    halver_en && ref_count_pulse |=> pfd_ref != $past(pfd_ref))
    else $error("halver did not toggle on counter pulse");

  // The bypass path must keep the one-flop latency of the halver path,
  // or the detector sees a phase step whenever the halver is switched.
  a_halver_bypass: assert property ( // RULE_10
    @(posedge clk) disable iff (sys_rst)
    !halver_en |=> pfd_ref == $past(ref_count_pulse))
    else $error("bypassed reference pulse not passed through");

  // ==========================================================
  // Ramp-down pacing
  // ==========================================================
  // Cells come off at a fixed pace so the loop filter sees gentle steps.
  always_ff @(posedge clk) begin
    if (sys_rst || state_ff != CSAC_RAMP_DOWN || step_tick) begin
      step_cnt_ff <= 16'h0000;
    end else begin
      step_cnt_ff <= step_cnt_ff + 16'h0001;
    end
  end
  assign step_tick = (state_ff == CSAC_RAMP_DOWN) &&
                     (step_cnt_ff == 16'(STEP_CYCLES - 1));

  // ==========================================================
  // Cell ramp
  // ==========================================================
  always_ff @(posedge clk) begin
    if (sys_rst || !slip_assist_enable) begin // RULE_05 RULE_11
      state_ff <= CSAC_IDLE;
      cells_ff <= '0;
    end else begin
      case (state_ff)
        CSAC_IDLE, CSAC_RAMP_UP: begin
          if (detect.overshoot && cells_ff[0]) begin
            state_ff <= CSAC_RAMP_DOWN; // RULE_04
          end else if (detect.slip_imminent && !cells_ff[MAX_CELLS-1]) begin
            state_ff <= CSAC_RAMP_UP;
            cells_ff <= {cells_ff[MAX_CELLS-2:0], 1'b1}; // RULE_01 RULE_03
          end
        end
        CSAC_RAMP_DOWN: begin
          if (!cells_ff[0]) begin
            state_ff <= CSAC_IDLE;
          end else if (step_tick) begin
            cells_ff <= {1'b0, cells_ff[MAX_CELLS-1:1]}; // RULE_04
          end
        end
        default: begin
          state_ff <= CSAC_IDLE;
          cells_ff <= '0;
        end
      endcase
    end
  end

  // Direction is latched when the first cell comes on and held while any
  // cell drives, so the current never reverses mid-ramp.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      source_ff <= 1'b0;
    end else if (slip_assist_enable && !cells_ff[0] &&
                 detect.slip_imminent && state_ff != CSAC_RAMP_DOWN) begin
      source_ff <= detect.raise; // RULE_01
    end
  end

  // Level enables held between steps give a constant, unpulsed current.
  assign cell_ctrl.cells  = cells_ff; // RULE_02
  assign cell_ctrl.source = source_ff;

  a_slip_adds_one: assert property ( // RULE_01
    @(posedge clk) disable iff (sys_rst)
    slip_assist_enable && state_ff != CSAC_RAMP_DOWN &&
    detect.slip_imminent && !detect.overshoot && !cells_ff[MAX_CELLS-1]
    |=> cells_ff == {$past(cells_ff[MAX_CELLS-2:0]), 1'b1})
    else $error("imminent slip did not add one cell");

  a_cells_max: assert property ( // RULE_03
    @(posedge clk) disable iff (sys_rst)
    cells_ff[MAX_CELLS-1] && slip_assist_enable && detect.slip_imminent &&
    state_ff != CSAC_RAMP_DOWN |=> cells_ff == {MAX_CELLS{1'b1}})
    else $error("cell count moved past seven");

  // A gap in the thermometer would mean a cell drives while a lower one
  // is off, which the ramp never does.
  a_thermo_shape: assert property ( // RULE_02
    @(posedge clk) disable iff (sys_rst)
    ((cells_ff + 1'b1) & cells_ff) == '0)
    else $error("cell enables not a thermometer");

  a_thermo_steady: assert property ( // RULE_02
    @(posedge clk) disable iff (sys_rst)
    slip_assist_enable && !detect.slip_imminent &&
    state_ff != CSAC_RAMP_DOWN |=> cells_ff == $past(cells_ff))
    else $error("cell enables moved without a slip");

  a_overshoot_down: assert property ( // RULE_04
    @(posedge clk) disable iff (sys_rst)
    slip_assist_enable && state_ff != CSAC_RAMP_DOWN &&
    detect.overshoot && cells_ff[0] |=> state_ff == CSAC_RAMP_DOWN)
    else $error("overshoot did not start the ramp down");

  a_ramp_down: assert property ( // RULE_04
    @(posedge clk) disable iff (sys_rst)
    slip_assist_enable && state_ff == CSAC_RAMP_DOWN && step_tick &&
    cells_ff[0] |=> cells_ff == {1'b0, $past(cells_ff[MAX_CELLS-1:1])})
    else $error("ramp down did not drop one cell");

  a_down_ignores_slip: assert property ( // RULE_04
    @(posedge clk) disable iff (sys_rst)
    state_ff == CSAC_RAMP_DOWN && !step_tick && cells_ff[0] &&
    slip_assist_enable |=> $stable(cells_ff))
    else $error("cells changed between ramp-down steps");

  a_empty_idle: assert property ( // RULE_04
    @(posedge clk) disable iff (sys_rst)
    slip_assist_enable && state_ff == CSAC_RAMP_DOWN && !cells_ff[0]
    |=> state_ff == CSAC_IDLE)
    else $error("ramp down did not return to idle");

  a_disable_clears: assert property ( // RULE_05 RULE_11
    @(posedge clk) disable iff (sys_rst)
    !slip_assist_enable |=> cells_ff == '0 ##0 state_ff == CSAC_IDLE)
    else $error("cells active while assist disabled");

  a_source_held: assert property ( // RULE_01
    @(posedge clk) disable iff (sys_rst)
    cells_ff[0] && $past(cells_ff[0]) |-> $stable(source_ff))
    else $error("direction changed while cells drive");

endmodule

//--- testbench/csac_vco_model.sv
// Far-side model: loop filter and oscillator events reported as detect.
`timescale 1ns/10ps
module csac_vco_model (
  input  wire logic                  clk,
  input  wire logic                  slip_req,
  input  wire logic                  over_req,
  input  wire logic                  raise_req,
  input  wire csac_pkg::csac_cells_s cell_ctrl,
  output csac_pkg::csac_detect_s     detect
);
  import csac_pkg::*;
  // An oscillator can only overshoot while extra current is flowing.
  always_ff @(posedge clk) begin
    detect.slip_imminent <= slip_req;
    detect.overshoot     <= over_req & (|cell_ctrl.cells);
    detect.raise         <= raise_req;
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the slip assist control block.
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  err_count++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
  import csac_pkg::*;
  logic         clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]   paddr = 0;
  logic [31:0]  pwdata = 0, prdata, r;
  logic         pready, pslverr, e, pfd_ref, p0, slip_assist_enable;
  logic         ref_count_pulse = 0, slip_req = 0, over_req = 0;
  logic         raise_req = 1;
  csac_detect_s detect;
  csac_cells_s  cell_ctrl;
  int           err_count = 0, comparisons = 0, cyc = 0;
  csac_top #(.STEP_CYCLES(2)) u_csac_top (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .detect(detect), .ref_count_pulse(ref_count_pulse), .pfd_ref(pfd_ref),
    .cell_ctrl(cell_ctrl), .slip_assist_enable(slip_assist_enable));
  csac_vco_model u_csac_vco_model (.clk(clk), .slip_req(slip_req),
    .over_req(over_req), .raise_req(raise_req), .cell_ctrl(cell_ctrl),
    .detect(detect));
  initial forever #5 clk = ~clk;
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Waits, within a bound, for the cell enables to leave a given value.
  task automatic wait_cells(input logic [6:0] old);
    int n;
    n = 0;
    while (cell_ctrl.cells === old && n < 50) begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      complete_run();
    end
  end
  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    apb(1'b1, FUNC_SETUP_OFS, 32'h0000_0040);
    apb(1'b1, REF_DIVIDER_OFS, 32'h1020_0000);
    @(posedge clk);
    `CHK(slip_assist_enable, 1'b1)
    // Evenly spaced counter pulses give the halved signal equal halves.
    for (int k = 0; k < 4; k++) begin
      p0 = pfd_ref;
      ref_count_pulse <= 1;
      @(posedge clk);
      ref_count_pulse <= 0;
      repeat (3) @(posedge clk);
      `CHK(pfd_ref, ~p0)
    end
    slip_req <= 1;
    @(posedge clk);
    slip_req <= 0;
    wait_cells(7'h00);
    `CHK(cell_ctrl, {7'h01, 1'b1})
    repeat (5) @(posedge clk);
    `CHK(cell_ctrl, {7'h01, 1'b1})
    slip_req <= 1;
    repeat (10) @(posedge clk);
    slip_req <= 0;
    repeat (3) @(posedge clk);
    `CHK(cell_ctrl.cells, 7'h7F)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(r, 32'h0000_117F)
    over_req <= 1;
    @(posedge clk);
    over_req <= 0;
    for (int i = 6; i >= 0; i--) begin
      wait_cells(cell_ctrl.cells);
      `CHK(cell_ctrl.cells, 7'h7F >> (7 - i))
    end
    raise_req <= 0;
    slip_req <= 1;
    repeat (3) @(posedge clk);
    slip_req <= 0;
    repeat (2) @(posedge clk);
    `CHK(cell_ctrl, {7'h07, 1'b0})
    apb(1'b1, REF_DIVIDER_OFS, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(cell_ctrl.cells, 7'h00)
    ref_count_pulse <= 1;
    @(posedge clk);
    ref_count_pulse <= 0;
    @(posedge clk);
    `CHK(pfd_ref, 1'b1)
    slip_req <= 1;
    repeat (4) @(posedge clk);
    slip_req <= 0;
    `CHK(cell_ctrl.cells, 7'h00)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
    complete_run();
  end
endmodule
